// *** inc/acss_consts.svh ***
// Offsets, field positions, reset values and timing counts of the clock source selector.
`ifndef ACSS_CONSTS_SVH
`define ACSS_CONSTS_SVH

`define ACSS_CLK_HZ 100000000
`define ACSS_CLK_PERIOD_NS 10

// Register byte offsets.
`define ACSS_OFS_CTRL 8'h00
`define ACSS_OFS_STATUS 8'h04
`define ACSS_OFS_INPUTS 8'h08
`define ACSS_OFS_IRQ_STAT 8'h0C
`define ACSS_OFS_IRQ_MASK 8'h10

// Control register fields.
`define ACSS_CTRL_FOLLOW 0
`define ACSS_CTRL_PREF_LSB 1
`define ACSS_CTRL_RATE_LSB 4
`define ACSS_CTRL_RESET 32'h0000_0031

// Status register fields.
`define ACSS_ST_SRC_LSB 0
`define ACSS_ST_EXT 2
`define ACSS_ST_RATE_LSB 3
`define ACSS_ST_MISMATCH 6
`define ACSS_ST_SPEED_LSB 7
`define ACSS_ST_CHANS_LSB 9

// Input status register: 2-bit state at 2*i, 3-bit rate at 8+3*i.
`define ACSS_IN_RATE_LSB 8

// Interrupt bits.
`define ACSS_IRQ_SRC_CHANGE 0
`define ACSS_IRQ_REF_LOST 1
`define ACSS_IRQ_MISMATCH 2
`define ACSS_IRQ_LOCK_CHANGE 3
`define ACSS_IRQ_WIDTH 4
`define ACSS_IRQ_MASK_RESET 4'h0

// Reference loss time and its cycle count.
`define ACSS_LOSS_TIME_US 100
`define ACSS_LOSS_CYCLES ((`ACSS_LOSS_TIME_US * 1000) / `ACSS_CLK_PERIOD_NS)

// Nominal sample periods in clock cycles, rounded down.
`define ACSS_PER_32K (`ACSS_CLK_HZ / 32000)
`define ACSS_PER_44K1 (`ACSS_CLK_HZ / 44100)
`define ACSS_PER_48K (`ACSS_CLK_HZ / 48000)
`define ACSS_PER_88K2 (`ACSS_CLK_HZ / 88200)
`define ACSS_PER_96K (`ACSS_CLK_HZ / 96000)
`define ACSS_PER_176K4 (`ACSS_CLK_HZ / 176400)
`define ACSS_PER_192K (`ACSS_CLK_HZ / 192000)

// Match tolerance as a right shift of the nominal period, 1/32.
`define ACSS_TOL_SHIFT 5

`endif

// *** inc/acss_pkg.sv ***
// Types and the rate period table of the clock source selector.
`include "acss_consts.svh"

package acss_pkg;

  typedef enum logic [1:0] {
    SRC_WORD = 2'h0,
    SRC_AES = 2'h1,
    SRC_SPDIF = 2'h2,
    SRC_OPT = 2'h3
  } acss_src_t;

  typedef enum logic [2:0] {
    RATE_NONE = 3'h0,
    RATE_32K = 3'h1,
    RATE_44K1 = 3'h2,
    RATE_48K = 3'h3,
    RATE_88K2 = 3'h4,
    RATE_96K = 3'h5,
    RATE_176K4 = 3'h6,
    RATE_192K = 3'h7
  } acss_rate_t;

  typedef enum logic [1:0] {
    IN_NO_LOCK = 2'h0,
    IN_LOCK = 2'h1,
    IN_SYNC = 2'h2
  } acss_in_state_t;

  typedef enum logic [1:0] {
    SPEED_SINGLE = 2'h0,
    SPEED_DOUBLE = 2'h1,
    SPEED_QUAD = 2'h2
  } acss_speed_t;

  typedef enum logic [1:0] {
    ST_INTERNAL = 2'b00,
    ST_FOLLOW = 2'b01,
    ST_LOST = 2'b11
  } acss_state_t;

  function automatic logic [15:0] acss_nominal_period(input logic [2:0] code);
    logic [15:0] per;
    per = 16'(`ACSS_PER_48K);
    case (code)
      3'h1: per = 16'(`ACSS_PER_32K);
      3'h2: per = 16'(`ACSS_PER_44K1);
      3'h3: per = 16'(`ACSS_PER_48K);
      3'h4: per = 16'(`ACSS_PER_88K2);
      3'h5: per = 16'(`ACSS_PER_96K);
      3'h6: per = 16'(`ACSS_PER_176K4);
      3'h7: per = 16'(`ACSS_PER_192K);
      default: per = 16'(`ACSS_PER_48K);
    endcase
    return per;
  endfunction

endpackage

// *** logic/acss_ref_monitor.sv ***
// Watches one reference input: synchronises it, measures its period and reports lock and rate.
`timescale 1ns/10ps
`include "acss_consts.svh"

module acss_ref_monitor #(
  parameter int LOSS_CYCLES = `ACSS_LOSS_CYCLES
) (
  input wire logic clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic ref_pin, // Reference clock from the pin.
  output logic edge_pulse, // One-cycle pulse per reference rising edge.
  output logic locked, // Valid signal with a recognised rate.
  output logic [2:0] rate_code // Detected rate, none while unlocked.
);

  logic s1_reg, s2_reg, s3_reg;
  logic [15:0] cnt_reg;
  logic [2:0] last_code_reg;
  logic [2:0] rate_reg;
  logic lock_reg;
  logic edge_reg;
  logic [2:0] meas_code;
  logic [15:0] nom;
  logic [15:0] tol;

  wire rise = s2_reg & ~s3_reg;
  wire timeout = cnt_reg >= 16'(LOSS_CYCLES);
  wire [15:0] cnt_inc = (cnt_reg == 16'hFFFF) ? cnt_reg : cnt_reg + 16'h0001;

  // Classifies the last period against every known rate within about three percent.
  always_comb begin
    meas_code = 3'h0;
    nom = 16'h0000;
    tol = 16'h0000;
    for (int i = 1; i < 8; i++) begin
      nom = acss_pkg::acss_nominal_period(3'(i));
      tol = nom >> `ACSS_TOL_SHIFT;
      if (cnt_reg >= nom - tol && cnt_reg <= nom + tol) begin
        meas_code = 3'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= ref_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // The input is watched on every cycle, whatever the selector is doing. [RULE_01]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 16'h0000;
      last_code_reg <= 3'h0;
      rate_reg <= 3'h0;
      lock_reg <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      edge_reg <= rise;
      cnt_reg <= rise ? 16'h0001 : cnt_inc;
      if (rise) begin
        last_code_reg <= meas_code;
        if (meas_code != 3'h0 && meas_code == last_code_reg) begin
          rate_reg <= meas_code; // [RULE_07]
          lock_reg <= 1'b1;
        end else if (meas_code == 3'h0) begin
          rate_reg <= 3'h0; // [RULE_07]
          lock_reg <= 1'b0;
        end
      end else if (timeout) begin
        rate_reg <= 3'h0; // [RULE_07]
        lock_reg <= 1'b0;
        last_code_reg <= 3'h0;
      end
    end
  end

  assign edge_pulse = edge_reg;
  assign locked = lock_reg;
  assign rate_code = rate_reg;

endmodule // acss_ref_monitor

// *** logic/acss_rate_tick.sv ***
// Internal oscillator divider that ticks once per sample at the requested rate.
`timescale 1ns/10ps
`include "acss_consts.svh"

module acss_rate_tick (
  input wire logic clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [2:0] rate_code, // Requested rate; none runs at 48 kHz.
  output logic tick // One-cycle pulse per internal sample.
);

  logic [15:0] cnt_reg;
  logic tick_reg;

  wire [15:0] per = acss_pkg::acss_nominal_period(rate_code);
  wire wrap = cnt_reg >= per - 16'h0001;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
      tick_reg <= wrap;
    end
  end

  assign tick = tick_reg;

endmodule // acss_rate_tick

// *** logic/acss_clock_select.sv ***
// Sample clock reference selector with per-input status, rate checks and register access.
//
// Summary of operation
// [RULE_01] Automatic mode monitors every input continuously.
// [RULE_02] Valid input replaces internal oscillator as clock.
// [RULE_03] Lost reference falls back to internal master.
// [RULE_04] Preferred input wins while valid, else scan.
// [RULE_05] No valid input means internal clock mode.
// [RULE_06] Each input reports no lock, lock, sync.
// [RULE_07] Report detected rate; unrecognised rate shows no lock.
// [RULE_08] Optical link: double speed 4, quad 2 channels.
// [RULE_09] 88.2/96 double, 176.4/192 quad; withdraw channels.
// [RULE_10] Slaved: external rate kept, host request ignored.
// [RULE_11] Actual rate readable; mismatch raises error flag.
// [RULE_12] Playback sample pacing follows the recovered clock.
// [RULE_13] Fallback order: word, AES, SPDIF, optical.
// [RULE_14] Only one master; others must receive clock.
`timescale 1ns/10ps
`include "acss_consts.svh"

module acss_clock_select #(
  parameter int LOSS_CYCLES = `ACSS_LOSS_CYCLES, // Reference loss timeout in cycles.
  parameter int NUM_INPUTS = 4, // Word clock, AES, SPDIF, optical.
  parameter int OPT_CHANNELS = 8 // Optical link channels at single speed.
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic word_clk_pin, // Word clock reference input.
  input wire logic aes_ref_pin, // Clock recovered from the AES receiver.
  input wire logic spdif_ref_pin, // Clock recovered from the coaxial receiver.
  input wire logic opt_ref_pin, // Clock recovered from the optical eight channel link.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_we, // Register write strobe.
  input wire logic reg_re, // Register read strobe.
  output logic [31:0] reg_rdata, // Read data, valid the cycle after the strobe.
  output logic irq, // Level interrupt.
  output logic sample_tick, // Playback sample pacing pulse.
  output logic clock_master, // High while running from the internal oscillator.
  output logic [1:0] cur_src, // Current reference source.
  output logic [2:0] eff_rate, // Effective sample rate code.
  output logic rate_mismatch, // Reference rate differs from the requested rate.
  output logic [7:0] opt_chan_en, // Usable optical link channels.
  output logic [2:0] opt_mux_factor // Link channels per audio channel: 1, 2 or 4.
);

  // Per-input monitors.
  logic [NUM_INPUTS-1:0] ref_pins;
  logic [NUM_INPUTS-1:0] locked;
  logic [NUM_INPUTS-1:0] edges;
  logic [2:0] rates [NUM_INPUTS];

  assign ref_pins = {opt_ref_pin, spdif_ref_pin, aes_ref_pin, word_clk_pin};

  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_mon
    acss_ref_monitor #(
      .LOSS_CYCLES(LOSS_CYCLES)
    ) u_mon (
      .clk(clk),
      .arst_n(arst_n),
      .ref_pin(ref_pins[g]),
      .edge_pulse(edges[g]),
      .locked(locked[g]),
      .rate_code(rates[g])
    );
  end

  // Software registers.
  logic [31:0] ctrl_reg;
  logic [`ACSS_IRQ_WIDTH-1:0] irq_stat_reg;
  logic [`ACSS_IRQ_WIDTH-1:0] irq_mask_reg;
  logic [31:0] rdata_reg;

  wire follow_en = ctrl_reg[`ACSS_CTRL_FOLLOW];
  wire [1:0] pref_src = ctrl_reg[`ACSS_CTRL_PREF_LSB +: 2];
  wire [2:0] req_rate = ctrl_reg[`ACSS_CTRL_RATE_LSB +: 3];

  // Candidate reference: the preferred input if valid, otherwise the first valid one.
  wire pref_ok = locked[pref_src]; // [RULE_04]
  wire any_lock = |locked;
  wire [1:0] scan_src = locked[0] ? 2'h0 :
                        locked[1] ? 2'h1 :
                        locked[2] ? 2'h2 : 2'h3; // [RULE_13]
  wire [1:0] cand_src = pref_ok ? pref_src : scan_src; // [RULE_04]

  // Reference selection state machine.
  acss_pkg::acss_state_t state_reg, state_next;
  logic [1:0] src_reg, src_next;

  always_comb begin
    state_next = state_reg;
    src_next = src_reg;
    case (state_reg)
      acss_pkg::ST_INTERNAL: begin
        if (follow_en && any_lock) begin
          state_next = acss_pkg::ST_FOLLOW; // [RULE_02]
          src_next = cand_src;
        end
      end
      acss_pkg::ST_FOLLOW: begin
        if (!follow_en) begin
          state_next = acss_pkg::ST_INTERNAL;
        end else if (!locked[src_reg]) begin
          state_next = acss_pkg::ST_LOST; // [RULE_03]
        end else if (pref_ok && src_reg != pref_src) begin
          src_next = pref_src; // [RULE_04]
        end
      end
      acss_pkg::ST_LOST: begin
        // Falls back to the oscillator for a cycle, then rescans the inputs.
        state_next = acss_pkg::ST_INTERNAL; // [RULE_03] [RULE_05]
      end
      default: begin
        state_next = acss_pkg::ST_INTERNAL;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= acss_pkg::ST_INTERNAL;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      src_reg <= 2'h0;
    end else begin
      src_reg <= src_next;
    end
  end

  // Effective clock mode and rate.
  // While following, a host rate request only shows as a mismatch.
  wire external = state_reg == acss_pkg::ST_FOLLOW;
  wire [2:0] ref_rate = rates[src_reg];
  wire [2:0] eff_rate_w = external ? ref_rate : req_rate; // [RULE_10]
  wire mismatch_w = external && ref_rate != req_rate; // [RULE_11]
  wire is_double = eff_rate_w == acss_pkg::RATE_88K2 || eff_rate_w == acss_pkg::RATE_96K;
  wire is_quad = eff_rate_w == acss_pkg::RATE_176K4 || eff_rate_w == acss_pkg::RATE_192K;
  wire [1:0] speed_w = is_quad ? acss_pkg::SPEED_QUAD :
                       is_double ? acss_pkg::SPEED_DOUBLE : acss_pkg::SPEED_SINGLE; // [RULE_09]
  wire [2:0] mux_w = is_quad ? 3'h4 : is_double ? 3'h2 : 3'h1; // [RULE_08]
  wire [3:0] chans_w = is_quad ? 4'(OPT_CHANNELS / 4) :
                       is_double ? 4'(OPT_CHANNELS / 2) : 4'(OPT_CHANNELS); // [RULE_08]
  wire [7:0] chan_en_w = 8'((9'h001 << chans_w) - 9'h001); // [RULE_09]

  // Internal oscillator tick at the requested rate.
  logic int_tick;

  acss_rate_tick u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .rate_code(req_rate),
    .tick(int_tick)
  );

  // Two pacing pulses never meet at a handover: the second is dropped.
  logic tick_reg;
  wire tick_w = (external ? edges[src_reg] : int_tick) & ~tick_reg; // [RULE_12]

  // Per-input state: sync when locked at the effective rate.
  // In internal mode the effective rate is the requested one.
  logic [2*NUM_INPUTS-1:0] in_state_w;
  logic [3*NUM_INPUTS-1:0] in_rate_w;

  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_state
    assign in_state_w[2*g +: 2] = !locked[g] ? acss_pkg::IN_NO_LOCK :
                                  rates[g] == eff_rate_w ? acss_pkg::IN_SYNC :
                                  acss_pkg::IN_LOCK; // [RULE_06]
    assign in_rate_w[3*g +: 3] = rates[g]; // [RULE_07]
  end

  // Output registers.
  logic master_reg;
  logic [1:0] cur_src_reg;
  logic [2:0] eff_rate_reg;
  logic mismatch_reg;
  logic [7:0] chan_en_reg;
  logic [2:0] mux_reg;
  logic [NUM_INPUTS-1:0] locked_d_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_w;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      master_reg <= 1'b1;
      cur_src_reg <= 2'h0;
    end else begin
      master_reg <= !external; // [RULE_14]
      cur_src_reg <= src_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eff_rate_reg <= 3'h0;
      mismatch_reg <= 1'b0;
    end else begin
      eff_rate_reg <= eff_rate_w;
      mismatch_reg <= mismatch_w; // [RULE_11]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_en_reg <= 8'h00;
      mux_reg <= 3'h1;
    end else begin
      chan_en_reg <= chan_en_w; // [RULE_09]
      mux_reg <= mux_w;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      locked_d_reg <= '0;
    end else begin
      locked_d_reg <= locked;
    end
  end

  // Interrupt events.
  // Each event is a one-cycle pulse that the sticky status bit keeps.
  wire ev_src = state_next == acss_pkg::ST_FOLLOW &&
                (state_reg != acss_pkg::ST_FOLLOW || src_next != src_reg);
  wire ev_lost = state_reg == acss_pkg::ST_LOST;
  wire ev_mismatch = mismatch_w & ~mismatch_reg;
  wire ev_lock = locked != locked_d_reg;
  wire [`ACSS_IRQ_WIDTH-1:0] events = {ev_lock, ev_mismatch, ev_lost, ev_src};

  // Register decode.
  // Unmapped offsets read as zero and drop writes.
  wire sel_ctrl = reg_addr == `ACSS_OFS_CTRL;
  wire sel_status = reg_addr == `ACSS_OFS_STATUS;
  wire sel_inputs = reg_addr == `ACSS_OFS_INPUTS;
  wire sel_istat = reg_addr == `ACSS_OFS_IRQ_STAT;
  wire sel_imask = reg_addr == `ACSS_OFS_IRQ_MASK;
  wire [`ACSS_IRQ_WIDTH-1:0] w1c = (reg_we && sel_istat) ?
                                   reg_wdata[`ACSS_IRQ_WIDTH-1:0] : '0;

  wire [31:0] status_w = {19'h0_0000, chans_w, speed_w, mismatch_reg,
                          eff_rate_reg, external, src_reg}; // [RULE_11]
  wire [31:0] inputs_w = {12'h000, in_rate_w, in_state_w}; // [RULE_06]
  wire [31:0] rd_mux = sel_ctrl ? ctrl_reg :
                       sel_status ? status_w :
                       sel_inputs ? inputs_w :
                       sel_istat ? {28'h000_0000, irq_stat_reg} :
                       sel_imask ? {28'h000_0000, irq_mask_reg} : 32'h0000_0000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `ACSS_CTRL_RESET;
    end else if (reg_we && sel_ctrl) begin
      ctrl_reg <= {25'h000_0000, reg_wdata[6:0]};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_reg <= `ACSS_IRQ_MASK_RESET;
    end else if (reg_we && sel_imask) begin
      irq_mask_reg <= reg_wdata[`ACSS_IRQ_WIDTH-1:0];
    end
  end

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= reg_re ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = |(irq_stat_reg & irq_mask_reg);
  assign sample_tick = tick_reg;
  assign clock_master = master_reg;
  assign cur_src = cur_src_reg;
  assign eff_rate = eff_rate_reg;
  assign rate_mismatch = mismatch_reg;
  assign opt_chan_en = chan_en_reg;
  assign opt_mux_factor = mux_reg;

endmodule // acss_clock_select

// *** verif/acss_clock_select_properties.sv ***
// Concurrent checks on the ports of the clock source selector.
`timescale 1ns/10ps
`include "acss_consts.svh"
module acss_clock_select_props #(
  parameter int LOSS_CYCLES = `ACSS_LOSS_CYCLES // Loss timeout in cycles.
) (
  input wire logic clk, // Clock.
  input wire logic arst_n, // Reset.
  input wire logic [7:0] reg_addr, // Address.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic reg_we, // Write strobe.
  input wire logic reg_re, // Read strobe.
  input wire logic [31:0] reg_rdata, // Read data.
  input wire logic irq, // Interrupt.
  input wire logic sample_tick, // Pacing pulse.
  input wire logic clock_master, // Internal clock.
  input wire logic [2:0] eff_rate, // Rate in use.
  input wire logic rate_mismatch, // Rate error.
  input wire logic [7:0] opt_chan_en, // Optical channels.
  input wire logic [2:0] opt_mux_factor // Channels per sample.
);
  logic [6:0] ctrl_reg;
  logic [6:0] ctrl_next;
  logic [3:0] mask_reg;
  logic [3:0] mask_next;
  logic [2:0] calm_reg;
  logic [2:0] calm_next;
  wire logic ctrl_wr = reg_we && reg_addr == `ACSS_OFS_CTRL;
  wire logic mask_wr = reg_we && reg_addr == `ACSS_OFS_IRQ_MASK;
  wire logic mapped = reg_addr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  assign ctrl_next = ctrl_wr ? reg_wdata[6:0] : ctrl_reg;
  assign mask_next = mask_wr ? reg_wdata[3:0] : mask_reg;
  assign calm_next = ctrl_wr ? 3'h0 : (calm_reg == 3'h7) ? calm_reg : calm_reg + 3'h1;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= 7'h31;
      mask_reg <= 4'h0;
      calm_reg <= 3'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      calm_reg <= calm_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  quad_chans_a: assert property (opt_mux_factor == 3'h4 |-> opt_chan_en == 8'h03)
    else $error("quad speed channel set wrong");
  double_chans_a: assert property (opt_mux_factor == 3'h2 |-> opt_chan_en == 8'h0F)
    else $error("double speed channel set wrong");
  master_match_a: assert property (clock_master |-> !rate_mismatch)
    else $error("mismatch flagged while master");
  read_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  unmapped_read_a: assert property (reg_re && !mapped |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property (reg_re && reg_addr == `ACSS_OFS_CTRL
    |=> reg_rdata == {25'h0, $past(ctrl_reg)}) else $error("control readback wrong");
  irq_mask_a: assert property (mask_reg == 4'h0 |-> !irq)
    else $error("interrupt with all masked");
  follow_off_a: assert property (!ctrl_reg[0] && calm_reg == 3'h7 |-> clock_master)
    else $error("following with follow disabled");
  tick_pulse_a: assert property (sample_tick |=> !sample_tick)
    else $error("pacing pulse too long");
  master_rate_a: assert property (calm_reg == 3'h7 && clock_master && $past(clock_master)
    && $past(clock_master, 2) && ctrl_reg[6:4] != 3'h0 |-> eff_rate == ctrl_reg[6:4])
    else $error("master rate differs from request");
  cover property ($fell(clock_master));
  cover property ($rose(clock_master));
  cover property (rate_mismatch && irq);
endmodule // acss_clock_select_props

bind acss_clock_select acss_clock_select_props #(.LOSS_CYCLES(LOSS_CYCLES)) i_props (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq),
  .sample_tick(sample_tick), .clock_master(clock_master), .eff_rate(eff_rate),
  .rate_mismatch(rate_mismatch), .opt_chan_en(opt_chan_en), .opt_mux_factor(opt_mux_factor)
);

// *** verif/acss_ref_source.sv ***
// Behavioural external source of one reference clock.
`timescale 1ns/10ps
module acss_ref_source (
  input wire logic enable, // Source connected.
  input wire logic [31:0] period_ns, // Reference period.
  output logic ref_pin // Reference clock.
);
  // Runs from its own timebase, never from the selector, and stays low when off.
  initial begin
    ref_pin = 1'b0;
    forever begin
      if (enable) begin
        #(period_ns / 2) ref_pin = 1'b1;
        #(period_ns - period_ns / 2) ref_pin = 1'b0;
      end else begin
        @(enable);
      end
    end
  end
endmodule // acss_ref_source

// *** verif/tb_audio_clock_source_select.sv ***
// Self-checking bench for the clock source selector.
`timescale 1ns/10ps
`include "acss_consts.svh"
module tb_audio_clock_source_select;
  localparam int LOSS = 4000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic irq, sample_tick, clock_master, rate_mismatch;
  logic [1:0] cur_src;
  logic [2:0] eff_rate, opt_mux_factor, r;
  logic [7:0] opt_chan_en;
  logic [3:0] pins, on;
  logic [3:0] src_on = 4'h0;
  logic [1:0] pref;
  int src_ns [4] = '{default: 5208};
  int num_errors = 0;
  int check_count = 0;

  always #5 clk = ~clk;

  acss_clock_select #(.LOSS_CYCLES(LOSS)) i_dut (
    .clk(clk), .arst_n(arst_n), .word_clk_pin(pins[0]), .aes_ref_pin(pins[1]),
    .spdif_ref_pin(pins[2]), .opt_ref_pin(pins[3]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .irq(irq), .sample_tick(sample_tick), .clock_master(clock_master), .cur_src(cur_src),
    .eff_rate(eff_rate), .rate_mismatch(rate_mismatch), .opt_chan_en(opt_chan_en),
    .opt_mux_factor(opt_mux_factor)
  );

  for (genvar g = 0; g < 4; g++) begin : g_src
    acss_ref_source i_src (.enable(src_on[g]), .period_ns(src_ns[g]), .ref_pin(pins[g]));
  end

  function automatic logic [10:0] spd(input logic [2:0] rc);
    if (rc >= 3'h6) return {3'h4, 8'h03};
    if (rc >= 3'h4) return {3'h2, 8'h0F};
    return {3'h1, 8'hFF};
  endfunction

  function automatic int per_ns(input logic [2:0] rc);
    case (rc)
      3'h4: return 11338;
      3'h5: return 10417;
      3'h6: return 5669;
      default: return 5208;
    endcase
  endfunction

  function automatic logic [1:0] pick(input logic [3:0] o, input logic [1:0] p);
    if (o[p]) return p;
    for (int i = 0; i < 4; i++) begin
      if (o[i]) return 2'(i);
    end
    return 2'h0;
  endfunction

  function automatic logic [31:0] exp_in(input logic [3:0] o, input logic [2:0] rc);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (o[i]) v = v | (32'h2 << (2 * i)) | (32'(rc) << (8 + 3 * i));
    end
    return v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic wait_master(input logic want, input int max);
    int n;
    n = 0;
    while (clock_master !== want && n < max) begin
      step(1);
      n++;
    end
    chk(32'(clock_master), 32'(want));
  endtask

  task automatic tick_gap(input int lo, input int hi);
    int n;
    n = 0;
    while (sample_tick !== 1'b1 && n < 4000) begin
      step(1);
      n++;
    end
    n = 0;
    do begin
      step(1);
      n++;
    end while (sample_tick !== 1'b1 && n < 4000);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The tests need about two fifths of this span.
  initial begin
    #1_000_000;
    num_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(26));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    step(1);
    chk({20'h0, eff_rate, opt_chan_en, clock_master}, {20'h0, 3'h3, 8'hFF, 1'b1});
    rdc(`ACSS_OFS_CTRL, 32'h0000_0031);
    rdc(`ACSS_OFS_IRQ_MASK, 32'h0000_0000);
    wr(8'h14, 32'hFFFF_FFFF);
    rdc(8'h14, 32'h0000_0000);
    for (int i = 1; i < 8; i++) begin
      r = 3'(i);
      wr(`ACSS_OFS_CTRL, {25'h0, r, 4'h1});
      step(3);
      chk({18'h0, eff_rate, opt_mux_factor, opt_chan_en}, {18'h0, r, spd(r)});
    end
    tick_gap(`ACSS_PER_192K, `ACSS_PER_192K);
    wr(`ACSS_OFS_IRQ_STAT, 32'h0000_000F);
    wr(`ACSS_OFS_IRQ_MASK, 32'h0000_000F);
    src_ns[3] <= 125;
    src_on[3] <= 1'b1;
    step(400);
    chk({31'h0, clock_master}, 32'h1);
    rdc(`ACSS_OFS_INPUTS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    src_on[3] <= 1'b0;
    wr(`ACSS_OFS_CTRL, 32'h0000_0031);
    wr(`ACSS_OFS_IRQ_MASK, 32'h0000_0001);
    src_ns[1] <= 10417;
    src_on[1] <= 1'b1;
    wait_master(1'b0, 6000);
    step(2);
    chk({30'h0, cur_src}, 32'h1);
    rdc(`ACSS_OFS_STATUS, {19'h0, 4'h4, 2'h1, 1'b1, 3'h5, 1'b1, 2'h1});
    chk({31'h0, irq}, 32'h1);
    wr(`ACSS_OFS_IRQ_STAT, 32'h0000_0001);
    step(1);
    chk({31'h0, irq}, 32'h0);
    src_on[2] <= 1'b1;
    step(2300);
    chk({30'h0, cur_src}, 32'h1);
    rdc(`ACSS_OFS_INPUTS, {12'h0, 3'h0, 3'h7, 3'h5, 3'h0, 8'h18});
    wr(`ACSS_OFS_CTRL, 32'h0000_0071);
    step(3);
    chk({28'h0, eff_rate, rate_mismatch}, {28'h0, 3'h5, 1'b1});
    wr(`ACSS_OFS_CTRL, 32'h0000_0051);
    step(3);
    chk({31'h0, rate_mismatch}, 32'h0);
    src_on[0] <= 1'b1;
    step(2300);
    chk({30'h0, cur_src}, 32'h0);
    tick_gap(519, 522);
    wr(`ACSS_OFS_CTRL, 32'h0000_0050);
    step(8);
    chk({31'h0, clock_master}, 32'h1);
    wr(`ACSS_OFS_CTRL, 32'h0000_0051);
    wait_master(1'b0, 20);
    src_on <= 4'h1;
    step(LOSS + 1200);
    wr(`ACSS_OFS_IRQ_STAT, 32'h0000_000F);
    wr(`ACSS_OFS_IRQ_MASK, 32'h0000_0002);
    src_on <= 4'h0;
    wait_master(1'b1, LOSS + 1200);
    step(4);
    chk({28'h0, eff_rate, irq}, {28'h0, 3'h5, 1'b1});
    tick_gap(`ACSS_PER_96K, `ACSS_PER_96K);
    for (int k = 0; k < 3; k++) begin
      on = 4'($urandom_range(15, 1));
      pref = 2'($urandom_range(3, 0));
      r = 3'($urandom_range(7, 4));
      wr(`ACSS_OFS_CTRL, {25'h0, r, 1'b0, pref, 1'b1});
      for (int i = 0; i < 4; i++) begin
        src_ns[i] <= per_ns(r);
      end
      src_on <= on;
      wait_master(1'b0, 6000);
      step(2);
      chk({30'h0, cur_src}, {30'h0, pick(on, pref)});
      rdc(`ACSS_OFS_INPUTS, exp_in(on, r));
      src_on <= 4'h0;
      wait_master(1'b1, LOSS + 1200);
    end
    end_of_test();
  end
endmodule // tb_audio_clock_source_select
